// *** rtl/dcfr_defines.svh ***
`ifndef DCFR_DEFINES_SVH
`define DCFR_DEFINES_SVH

// Register offsets on the serial link.
`define DCFR_SWITCH_CTRL_OFFSET 1'h0
`define DCFR_FAULT_READOUT_OFFSET 1'h1

// Reset values.
`define DCFR_SWITCH_CTRL_RESET 8'h00
`define DCFR_FAULT_READOUT_RESET 24'h000000

// Field positions inside the fault readout word.
`define DCFR_OC_MSB 23
`define DCFR_OC_LSB 16
`define DCFR_OS_MSB 15
`define DCFR_OS_LSB 8
`define DCFR_RSVD_BIT 7
`define DCFR_TSD_BIT 6
`define DCFR_CRC_MSB 5
`define DCFR_CRC_LSB 0

// Checksum polynomial and widths.
`define DCFR_CRC_POLY 7'h43
`define DCFR_CRC_WIDTH 6
`define DCFR_CHAN_COUNT 8
`define DCFR_READOUT_WIDTH 24

`endif

// *** rtl/dcfr_pkg.sv ***
`include "dcfr_defines.svh"

package dcfr_pkg;
    typedef logic [`DCFR_CHAN_COUNT-1:0] dcfr_chan_t;
    typedef logic [`DCFR_READOUT_WIDTH-1:0] dcfr_word_t;
    typedef logic [`DCFR_CRC_WIDTH-1:0] dcfr_crc_t;
endpackage : dcfr_pkg

// *** rtl/dcfr_crc6.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dcfr_defines.svh"

module dcfr_crc6
    import dcfr_pkg::*;
(
    input wire dcfr_chan_t data_i,
    output dcfr_crc_t crc_o
);

    // Divides the data with six appended zeros by the polynomial.
    function automatic dcfr_crc_t crc_calc(input dcfr_chan_t d);
        logic [13:0] rem;
        logic [13:0] poly_w;
        rem = {d, 6'h00};
        poly_w = {7'h00, `DCFR_CRC_POLY};
        for (int i = 13; i >= 6; i--) begin
            if (rem[i]) begin
                rem = rem ^ (poly_w << (i - 6));
            end
        end
        return rem[5:0];
    endfunction : crc_calc

    assign crc_o = crc_calc(data_i);

endmodule : dcfr_crc6
`default_nettype wire

// *** rtl/dcfr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dcfr_defines.svh"

// How it works
// - A 1 in a configuration bit turns that channel's switch on, 0 off.
// - Configuration bit n drives channel n; the register cannot be read.
// - Reset clears configuration and every fault flag to zero.
// - Readout bits 23 to 16 are overcurrent flags, channel seven down to zero.
// - Readout bits 15 to 8 are open-or-short flags, channel seven down to zero.
// - Fault flags stay set until read out, then hold only the faults still detected at the latch edge.
// - Configuration sits at offset 0, fault readout at offset 1.
// - Readout bit 6 is a read-to-clear thermal flag; bit 7 is reserved.
// - Readout bits 5 to 0 carry a checksum of the configuration value.
// - Checksum is eight bits plus six zeros modulo polynomial 1000011.
// - Latch edge loads readout MSB first; each shift falling edge moves one bit.
module dcfr_regs
    import dcfr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic shift_clock_i,
    input wire logic latch_clock_i,
    input wire logic serial_input_i,
    input wire logic [`DCFR_CHAN_COUNT-1:0] overcurrent_detect_i,
    input wire logic [`DCFR_CHAN_COUNT-1:0] open_short_detect_i,
    input wire logic thermal_detect_i,
    output logic serial_output_o,
    output logic [`DCFR_CHAN_COUNT-1:0] channel_switch_o
);

    // Pin synchronisers: stage one feeds stage two; the shift and latch clocks add a third stage for edge detection.
    logic [2:0] sclk_sync_reg;
    logic [2:0] lclk_sync_reg;
    logic [1:0] sdi_sync_reg;
    dcfr_chan_t oc_sync1_reg;
    dcfr_chan_t oc_sync2_reg;
    dcfr_chan_t os_sync1_reg;
    dcfr_chan_t os_sync2_reg;
    logic [1:0] tsd_sync_reg;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_sync_reg <= 3'h0;
            lclk_sync_reg <= 3'h0;
            sdi_sync_reg <= 2'h0;
            oc_sync1_reg <= 8'h00;
            oc_sync2_reg <= 8'h00;
            os_sync1_reg <= 8'h00;
            os_sync2_reg <= 8'h00;
            tsd_sync_reg <= 2'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], shift_clock_i};
            lclk_sync_reg <= {lclk_sync_reg[1:0], latch_clock_i};
            sdi_sync_reg <= {sdi_sync_reg[0], serial_input_i};
            oc_sync1_reg <= overcurrent_detect_i;
            oc_sync2_reg <= oc_sync1_reg;
            os_sync1_reg <= open_short_detect_i;
            os_sync2_reg <= os_sync1_reg;
            tsd_sync_reg <= {tsd_sync_reg[0], thermal_detect_i};
        end
    end

    logic shift_rise;
    logic shift_fall;
    logic latch_rise;
    assign shift_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign shift_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    assign latch_rise = lclk_sync_reg[1] & ~lclk_sync_reg[2];

    // Input shift chain, loaded on shift clock rising edges.
    dcfr_chan_t in_shift_reg;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            in_shift_reg <= `DCFR_SWITCH_CTRL_RESET;
        end else if (shift_rise) begin
            in_shift_reg <= {in_shift_reg[6:0], sdi_sync_reg[1]};
        end
    end

    // Switch control register, write-only, loaded on the latch edge.
    dcfr_chan_t switch_ctrl_reg;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            switch_ctrl_reg <= `DCFR_SWITCH_CTRL_RESET;
        end else if (latch_rise) begin
            switch_ctrl_reg <= in_shift_reg;
        end
    end

    // Channel n follows bit n; thermal shutdown forces every switch open.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            channel_switch_o <= 8'h00;
        end else begin
            channel_switch_o <= switch_ctrl_reg & {8{~tsd_sync_reg[1]}};
        end
    end

    // Sticky fault flags; a new detection wins over the clearing read.
    dcfr_chan_t oc_set;
    dcfr_chan_t os_set;
    logic tsd_set;
    dcfr_chan_t oc_flags_reg;
    dcfr_chan_t os_flags_reg;
    logic tsd_flag_reg;
    assign oc_set = oc_sync2_reg & switch_ctrl_reg;
    assign os_set = os_sync2_reg & switch_ctrl_reg;
    assign tsd_set = tsd_sync_reg[1];

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            oc_flags_reg <= 8'h00;
            os_flags_reg <= 8'h00;
            tsd_flag_reg <= 1'b0;
        end else if (latch_rise) begin
            oc_flags_reg <= oc_set;
            os_flags_reg <= os_set;
            tsd_flag_reg <= tsd_set;
        end else begin
            oc_flags_reg <= oc_flags_reg | oc_set;
            os_flags_reg <= os_flags_reg | os_set;
            tsd_flag_reg <= tsd_flag_reg | tsd_set;
        end
    end

    dcfr_crc_t crc_value;
    dcfr_crc6 u_crc (
        .data_i(in_shift_reg),
        .crc_o(crc_value)
    );

    // Readout word assembled at the latch edge.
    dcfr_word_t fault_word;
    always_comb begin
        fault_word = `DCFR_FAULT_READOUT_RESET;
        fault_word[`DCFR_OC_MSB:`DCFR_OC_LSB] = oc_flags_reg | oc_set;
        fault_word[`DCFR_OS_MSB:`DCFR_OS_LSB] = os_flags_reg | os_set;
        fault_word[`DCFR_RSVD_BIT] = 1'b0;
        fault_word[`DCFR_TSD_BIT] = tsd_flag_reg | tsd_set;
        fault_word[`DCFR_CRC_MSB:`DCFR_CRC_LSB] = crc_value;
    end

    // Output chain: MSB appears at the latch edge, shifts on falling edges.
    dcfr_word_t readout_reg;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            readout_reg <= `DCFR_FAULT_READOUT_RESET;
        end else if (latch_rise) begin
            readout_reg <= fault_word;
        end else if (shift_fall) begin
            readout_reg <= {readout_reg[22:0], 1'b0};
        end
    end

    assign serial_output_o = readout_reg[23];

    reset_clear_a: assert property (@(posedge clock_i)
        $fell(rst_i) |-> (switch_ctrl_reg == 8'h00) && (oc_flags_reg == 8'h00)
            && (os_flags_reg == 8'h00) && !tsd_flag_reg)
        else $error("state not zero after reset");

    switch_follow_a: assert property (@(posedge clock_i) disable iff (rst_i)
        latch_rise && !tsd_sync_reg[1] ##1 !tsd_sync_reg[1]
            |=> channel_switch_o == $past(in_shift_reg, 2))
        else $error("switch does not follow latched bit");

    thermal_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
        tsd_sync_reg[1] |=> channel_switch_o == 8'h00)
        else $error("switch on during thermal shutdown");

    oc_field_a: assert property (@(posedge clock_i) disable iff (rst_i)
        latch_rise |=> readout_reg[23:16] == $past(oc_flags_reg | oc_set))
        else $error("overcurrent field wrong");

    os_field_a: assert property (@(posedge clock_i) disable iff (rst_i)
        latch_rise |=> readout_reg[15:8] == $past(os_flags_reg | os_set))
        else $error("open short field wrong");

    flag_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !latch_rise |=> (oc_flags_reg & $past(oc_flags_reg)) == $past(oc_flags_reg)
            && (os_flags_reg & $past(os_flags_reg)) == $past(os_flags_reg))
        else $error("flag lost before read");

    read_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
        latch_rise && (oc_set == 8'h00) && (os_set == 8'h00) && !tsd_set
            |=> (oc_flags_reg == 8'h00) && (os_flags_reg == 8'h00) && !tsd_flag_reg)
        else $error("flag not cleared by read");

    status_byte_a: assert property (@(posedge clock_i) disable iff (rst_i)
        latch_rise |=> !readout_reg[7] && readout_reg[6] == $past(tsd_flag_reg | tsd_set))
        else $error("status bits wrong");

    crc_field_a: assert property (@(posedge clock_i) disable iff (rst_i)
        latch_rise |=> readout_reg[5:0] == $past(crc_value))
        else $error("checksum field wrong");

    crc_example_a: assert property (@(posedge clock_i) disable iff (rst_i)
        in_shift_reg == 8'hFF |-> crc_value == 6'h0D)
        else $error("checksum of FF is wrong");

    crc_single_a: assert property (@(posedge clock_i) disable iff (rst_i)
        in_shift_reg == 8'h01 |-> crc_value == 6'h03)
        else $error("checksum of 01 is wrong");

    serial_shift_a: assert property (@(posedge clock_i) disable iff (rst_i)
        shift_fall && !latch_rise |=> serial_output_o == $past(readout_reg[22]))
        else $error("serial output did not advance");

    refault_a: assert property (@(posedge clock_i) disable iff (rst_i)
        latch_rise ##1 (oc_set != 8'h00) |=> oc_flags_reg != 8'h00)
        else $error("flag not set again");

    read_oc_c: cover property (@(posedge clock_i) disable iff (rst_i)
        latch_rise && (oc_flags_reg != 8'h00));
    read_tsd_c: cover property (@(posedge clock_i) disable iff (rst_i)
        latch_rise && tsd_flag_reg);
    shift_out_c: cover property (@(posedge clock_i) disable iff (rst_i)
        shift_fall && serial_output_o);
    switch_on_c: cover property (@(posedge clock_i) disable iff (rst_i)
        channel_switch_o == 8'hFF);

endmodule : dcfr_regs
`default_nettype wire

// *** tb/dcfr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcfr_host_model
    import dcfr_pkg::*;
(
    input wire logic clock_i,
    input wire logic serial_output_i,
    output logic shift_clock_o,
    output logic latch_clock_o,
    output logic serial_input_o
);
    initial begin
        shift_clock_o = 1'b0;
        latch_clock_o = 1'b0;
        serial_input_o = 1'b0;
    end
    task automatic wait_half();
        repeat (10) @(posedge clock_i);
    endtask : wait_half
    task automatic pulse_shift(input logic bit_i);
        serial_input_o <= bit_i;
        wait_half();
        shift_clock_o <= 1'b1;
        wait_half();
        shift_clock_o <= 1'b0;
    endtask : pulse_shift
    task automatic transfer(input dcfr_chan_t cfg_i, output dcfr_word_t word_o);
        for (int i = 7; i >= 0; i--) begin
            pulse_shift(cfg_i[i]);
        end
        wait_half();
        latch_clock_o <= 1'b1;
        wait_half();
        latch_clock_o <= 1'b0;
        wait_half();
        word_o[23] = serial_output_i;
        for (int i = 22; i >= 0; i--) begin
            pulse_shift(~serial_input_o);
            wait_half();
            word_o[i] = serial_output_i;
        end
    endtask : transfer
endmodule : dcfr_host_model
`default_nettype wire

// *** tb/dcfr_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module dcfr_regs_tb
    import dcfr_pkg::*;
;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic sck, lck, sdi, sdo, th = 1'b0;
    dcfr_chan_t oc = 8'h00;
    dcfr_chan_t os = 8'h00;
    dcfr_chan_t sw;
    dcfr_chan_t cfgs[4] = '{8'hFF, 8'h00, 8'hA5, 8'h5A};
    int err_count = 0;
    int checks_done = 0;
    always #4 clock_i = ~clock_i;
    dcfr_regs dut (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .shift_clock_i(sck),
        .latch_clock_i(lck),
        .serial_input_i(sdi),
        .overcurrent_detect_i(oc),
        .open_short_detect_i(os),
        .thermal_detect_i(th),
        .serial_output_o(sdo),
        .channel_switch_o(sw)
    );
    dcfr_host_model host (
        .clock_i(clock_i),
        .serial_output_i(sdo),
        .shift_clock_o(sck),
        .latch_clock_o(lck),
        .serial_input_o(sdi)
    );
    function automatic dcfr_crc_t crc_of(input dcfr_chan_t d);
        logic [13:0] r;
        r = {d, 6'h00};
        for (int i = 13; i >= 6; i--) begin
            if (r[i]) begin
                r[i -: 7] = r[i -: 7] ^ 7'h43;
            end
        end
        return r[5:0];
    endfunction : crc_of
    task automatic xfer(input dcfr_chan_t cfg, input logic [17:0] flags);
        dcfr_word_t w;
        host.transfer(cfg, w);
        `CHK("readout", {flags, crc_of(cfg)}, w)
    endtask : xfer
    task automatic settle();
        repeat (10) @(posedge clock_i);
    endtask : settle
    task automatic end_of_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        `CHK("switches", 8'h00, sw)
        `CHK("serial out", 1'b0, sdo)
        foreach (cfgs[k]) begin
            xfer(cfgs[k], 18'h00000);
            settle();
            `CHK("switches", cfgs[k], sw)
        end
        oc <= 8'hFF;
        os <= 8'h0F;
        settle();
        oc <= 8'h00;
        os <= 8'h00;
        settle();
        xfer(8'h5A, {8'h5A, 8'h0A, 2'b00});
        xfer(8'h5A, 18'h00000);
        oc <= 8'h02;
        settle();
        xfer(8'h5A, {8'h02, 8'h00, 2'b00});
        xfer(8'h5A, {8'h02, 8'h00, 2'b00});
        oc <= 8'h00;
        th <= 1'b1;
        settle();
        `CHK("switches", 8'h00, sw)
        th <= 1'b0;
        settle();
        `CHK("switches", 8'h5A, sw)
        xfer(8'h5A, {8'h02, 8'h00, 2'b01});
        xfer(8'hC3, 18'h00000);
        `CHK("switches", 8'hC3, sw)
        oc <= 8'h01;
        settle();
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        oc <= 8'h00;
        repeat (3) @(posedge clock_i);
        `CHK("switches", 8'h00, sw)
        `CHK("serial out", 1'b0, sdo)
        xfer(8'h00, 18'h00000);
        end_of_test();
    end
endmodule : dcfr_regs_tb
`default_nettype wire
